//--- verilog/slsp_packer.sv
/*
 * Transport packer for the serial output lanes: places bypass samples or
 * decimated I/Q words with over-range flags into each lane frame word.
 * Assumes inputs synchronous to sys_clk; one frame is taken per in_valid.
 */
module slsp_packer #(
	parameter int DUAL_W = slsp_pkg::DUAL_W,
	parameter int IQ_W   = slsp_pkg::IQ_W,
	parameter int LANE_W = slsp_pkg::LANE_W
) (
	input  wire logic                                   sys_clk,
	input  wire logic                                   resetn,
	input  wire logic [slsp_pkg::MODE_W-1:0]            link_mode_select,
	input  wire logic                                   in_valid,
	input  wire logic [slsp_pkg::DUAL_COUNT*DUAL_W-1:0] chan_a_samples,
	input  wire logic [slsp_pkg::DUAL_COUNT*DUAL_W-1:0] chan_b_samples,
	input  wire logic [slsp_pkg::IQ_COUNT*IQ_W-1:0]     iq_i,
	input  wire logic [slsp_pkg::IQ_COUNT*IQ_W-1:0]     iq_q,
	input  wire logic [slsp_pkg::OVR_W-1:0]             overrange_i,
	input  wire logic [slsp_pkg::OVR_W-1:0]             overrange_q,
	output logic                                        out_valid,
	output logic                                        mode_supported,
	output logic      [LANE_W-1:0]                      lane_a0,
	output logic      [LANE_W-1:0]                      lane_a1,
	output logic      [LANE_W-1:0]                      lane_a2,
	output logic      [LANE_W-1:0]                      lane_a3,
	output logic      [LANE_W-1:0]                      lane_a4,
	output logic      [LANE_W-1:0]                      lane_a5,
	output logic      [LANE_W-1:0]                      lane_a6,
	output logic      [LANE_W-1:0]                      lane_a7,
	output logic      [LANE_W-1:0]                      lane_b0,
	output logic      [LANE_W-1:0]                      lane_b1,
	output logic      [LANE_W-1:0]                      lane_b2,
	output logic      [LANE_W-1:0]                      lane_b3,
	output logic      [LANE_W-1:0]                      lane_b4,
	output logic      [LANE_W-1:0]                      lane_b5,
	output logic      [LANE_W-1:0]                      lane_b6,
	output logic      [LANE_W-1:0]                      lane_b7
);
	import slsp_pkg::*;

	localparam int GROUP_W = 4 * DUAL_W;   // Four samples fill three lanes

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// Packing arithmetic only closes for these width relations
	if (GROUP_W != 3 * LANE_W || IQ_W + 1 != LANE_W) begin : g_bad_width
		$error("slsp_packer: widths do not fit the lane layout");
	end

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta;
	logic rst_n;

	// Async assert, two-stage synchronous release
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	slsp_layout_type     layout;
	logic [COUNT_W-1:0]  active_lanes;

	// Mode is treated as static; a change mid-stream takes effect next frame
	always_comb begin
		case (link_mode_select)
			MODE_20, MODE_43: layout = LAY_DUAL12;
			MODE_21, MODE_36: layout = LAY_D4_L4;
			MODE_22, MODE_46: layout = LAY_D4_L8;
			MODE_23, MODE_38, MODE_61, MODE_64, MODE_69, MODE_71: layout = LAY_D8_L2;
			MODE_24, MODE_48, MODE_62, MODE_65, MODE_70: layout = LAY_D8_L4;
			MODE_25, MODE_52: layout = LAY_D4_L16;
			default: layout = LAY_NONE;
		endcase
	end

	// Lanes in use per side; the rest idle at zero
	always_comb begin
		case (layout)
			LAY_DUAL12: active_lanes = ACT_DUAL;
			LAY_D4_L4:  active_lanes = ACT_TWO;
			LAY_D4_L8:  active_lanes = ACT_FOUR;
			LAY_D8_L2:  active_lanes = ACT_ONE;
			LAY_D8_L4:  active_lanes = ACT_TWO;
			LAY_D4_L16: active_lanes = ACT_EIGHT;
			default:    active_lanes = ACT_NONE;
		endcase
	end

	// ----------------------------------------------------------------
	// Lane word formation
	// ----------------------------------------------------------------
	logic [LANE_W-1:0] next_lane_a [LANES];
	logic [LANE_W-1:0] next_lane_b [LANES];
	logic [LANE_W-1:0] lane_a      [LANES];
	logic [LANE_W-1:0] lane_b      [LANES];

	for (genvar l = 0; l < LANES; l++) begin : g_lane
		localparam int GRP = l / 3;
		localparam int SUB = l % 3;
		localparam int FLG = (l < OVR_W) ? l : 0;
		logic [GROUP_W-1:0] grp_a;
		logic [GROUP_W-1:0] grp_b;
		logic [LANE_W-1:0]  dual_a;
		logic [LANE_W-1:0]  dual_b;
		logic [LANE_W-1:0]  iq_a;
		logic [LANE_W-1:0]  iq_b;
		logic               flag_i;
		logic               flag_q;
		logic               lane_on;

		if (l < DUAL_LANES) begin : g_dual
			assign grp_a = {chan_a_samples[(4*GRP)*DUAL_W +: DUAL_W],
				chan_a_samples[(4*GRP+1)*DUAL_W +: DUAL_W],
				chan_a_samples[(4*GRP+2)*DUAL_W +: DUAL_W],
				chan_a_samples[(4*GRP+3)*DUAL_W +: DUAL_W]};
			assign grp_b = {chan_b_samples[(4*GRP)*DUAL_W +: DUAL_W],
				chan_b_samples[(4*GRP+1)*DUAL_W +: DUAL_W],
				chan_b_samples[(4*GRP+2)*DUAL_W +: DUAL_W],
				chan_b_samples[(4*GRP+3)*DUAL_W +: DUAL_W]};
			assign dual_a = grp_a[GROUP_W-1-SUB*LANE_W -: LANE_W];
			assign dual_b = grp_b[GROUP_W-1-SUB*LANE_W -: LANE_W];
		end else begin : g_nodual
			assign grp_a  = '0;
			assign grp_b  = '0;
			assign dual_a = LANE_RESET;
			assign dual_b = LANE_RESET;
		end

		assign flag_i = (layout == LAY_D4_L16) ? overrange_i[l/2] : overrange_i[FLG];
		assign flag_q = (layout == LAY_D4_L16) ? overrange_q[l/2] : overrange_q[FLG];
		assign lane_on = (COUNT_W'(l) < active_lanes) && (layout != LAY_DUAL12);

		slsp_iq_word #(
			.IQ_W   (IQ_W),
			.LANE_W (LANE_W)
		) u_word_i (
			.sample (iq_i[l*IQ_W +: IQ_W]),
			.flag   (flag_i),
			.enable (lane_on),
			.word   (iq_a)
		);

		slsp_iq_word #(
			.IQ_W   (IQ_W),
			.LANE_W (LANE_W)
		) u_word_q (
			.sample (iq_q[l*IQ_W +: IQ_W]),
			.flag   (flag_q),
			.enable (lane_on),
			.word   (iq_b)
		);

		assign next_lane_a[l] = (layout == LAY_DUAL12) ? dual_a : iq_a;
		assign next_lane_b[l] = (layout == LAY_DUAL12) ? dual_b : iq_b;

		// Lanes hold their last frame between valid inputs
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				lane_a[l] <= LANE_RESET;
				lane_b[l] <= LANE_RESET;
			end else if (in_valid) begin
				lane_a[l] <= next_lane_a[l];
				lane_b[l] <= next_lane_b[l];
			end
		end
	end

	// ----------------------------------------------------------------
	// Frame status
	// ----------------------------------------------------------------
	// One cycle latency from frame in to lanes out
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid      <= 1'b0;
			mode_supported <= 1'b0;
		end else begin
			out_valid      <= in_valid;
			mode_supported <= (layout != LAY_NONE);
		end
	end

	// Flatten lane array onto named ports
	assign lane_a0 = lane_a[0];
	assign lane_a1 = lane_a[1];
	assign lane_a2 = lane_a[2];
	assign lane_a3 = lane_a[3];
	assign lane_a4 = lane_a[4];
	assign lane_a5 = lane_a[5];
	assign lane_a6 = lane_a[6];
	assign lane_a7 = lane_a[7];
	assign lane_b0 = lane_b[0];
	assign lane_b1 = lane_b[1];
	assign lane_b2 = lane_b[2];
	assign lane_b3 = lane_b[3];
	assign lane_b4 = lane_b[4];
	assign lane_b5 = lane_b[5];
	assign lane_b6 = lane_b[6];
	assign lane_b7 = lane_b[7];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	chk_dual_lane_zero: assert property (
		$past(in_valid && layout == LAY_DUAL12) |->
		lane_a0 == {$past(chan_a_samples[11:0]), $past(chan_a_samples[23:20])})
		else $error("bypass lane a0 misplaced");
	chk_dual_lane_one: assert property (
		$past(in_valid && layout == LAY_DUAL12) |->
		lane_a1 == {$past(chan_a_samples[19:12]), $past(chan_a_samples[35:28])})
		else $error("bypass lane a1 misplaced");
	chk_dual_lane_two: assert property (
		$past(in_valid && layout == LAY_DUAL12) |->
		lane_a2 == {$past(chan_a_samples[27:24]), $past(chan_a_samples[47:36])}
		&& lane_b5 == {$past(chan_b_samples[75:72]), $past(chan_b_samples[95:84])}
		&& lane_a6 == LANE_RESET)
		else $error("bypass nibble packing wrong");
	chk_mode_same_layout: assert property (
		$past(in_valid && link_mode_select == MODE_43) |->
		lane_a3 == {$past(chan_a_samples[59:48]), $past(chan_a_samples[71:68])})
		else $error("mode 43 layout differs");
	chk_d4_four_lanes: assert property (
		$past(in_valid && layout == LAY_D4_L4) |->
		lane_a1 == {$past(iq_i[29:15]), $past(overrange_i[1])} && lane_a2 == LANE_RESET)
		else $error("four lane word wrong");
	chk_d4_eight_lanes: assert property (
		$past(in_valid && layout == LAY_D4_L8) |->
		lane_b3 == {$past(iq_q[59:45]), $past(overrange_q[3])} && lane_b4 == LANE_RESET)
		else $error("eight lane word wrong");
	chk_d8_two_lanes: assert property (
		$past(in_valid && layout == LAY_D8_L2) |->
		lane_a0 == {$past(iq_i[14:0]), $past(overrange_i[0])} && lane_a1 == LANE_RESET)
		else $error("two lane word wrong");
	chk_d8_four_lanes: assert property (
		$past(in_valid && layout == LAY_D8_L4) |->
		lane_b1 == {$past(iq_q[29:15]), $past(overrange_q[1])} && lane_b2 == LANE_RESET)
		else $error("decimate-by-8 four lane word wrong");
	chk_shared_flag: assert property (
		$past(in_valid && layout == LAY_D4_L16) |->
		lane_a5 == {$past(iq_i[89:75]), $past(overrange_i[2])}
		&& lane_b7 == {$past(iq_q[119:105]), $past(overrange_q[3])})
		else $error("sixteen lane flag sharing wrong");
	chk_lane_hold: assert property (
		!in_valid |=> $stable(lane_a0) && $stable(lane_b7) && !out_valid)
		else $error("lane changed without frame");

	cov_bypass_burst: cover property ((in_valid && layout == LAY_DUAL12) [*3]);
	cov_sixteen: cover property (in_valid && layout == LAY_D4_L16 ##1 out_valid);
	cov_two_lane: cover property (in_valid && layout == LAY_D8_L2);
	cov_mode_switch: cover property (layout == LAY_D4_L8 ##1 layout == LAY_DUAL12);

endmodule

//--- verilog/slsp_pkg.sv
/*
 * Shared constants for the serial lane sample packer: link mode numbers,
 * lane layouts, sample and lane widths, reset values.
 * Assumes a single frame-clock domain; link coding happens downstream.
 */
package slsp_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DUAL_W      = 12;   // Converter sample, bypass modes
	localparam int DUAL_COUNT  = 8;    // Samples per channel per frame
	localparam int DUAL_LANES  = 6;    // Lanes per channel, bypass modes
	localparam int IQ_W        = 15;   // Decimated I or Q sample
	localparam int IQ_COUNT    = 8;    // Most I samples in one frame
	localparam int OVR_W       = 4;    // Over-range flags per component
	localparam int LANE_W      = 16;   // Lane frame word, two octets
	localparam int LANES       = 8;    // Lanes per side at most
	localparam int MODE_W      = 7;
	localparam int COUNT_W     = 4;

	// ----------------------------------------------------------------
	// Link mode numbers
	// ----------------------------------------------------------------
	localparam logic [MODE_W-1:0] MODE_20 = 7'h14;
	localparam logic [MODE_W-1:0] MODE_43 = 7'h2B;
	localparam logic [MODE_W-1:0] MODE_21 = 7'h15;
	localparam logic [MODE_W-1:0] MODE_36 = 7'h24;
	localparam logic [MODE_W-1:0] MODE_22 = 7'h16;
	localparam logic [MODE_W-1:0] MODE_46 = 7'h2E;
	localparam logic [MODE_W-1:0] MODE_23 = 7'h17;
	localparam logic [MODE_W-1:0] MODE_38 = 7'h26;
	localparam logic [MODE_W-1:0] MODE_61 = 7'h3D;
	localparam logic [MODE_W-1:0] MODE_64 = 7'h40;
	localparam logic [MODE_W-1:0] MODE_69 = 7'h45;
	localparam logic [MODE_W-1:0] MODE_71 = 7'h47;
	localparam logic [MODE_W-1:0] MODE_24 = 7'h18;
	localparam logic [MODE_W-1:0] MODE_48 = 7'h30;
	localparam logic [MODE_W-1:0] MODE_62 = 7'h3E;
	localparam logic [MODE_W-1:0] MODE_65 = 7'h41;
	localparam logic [MODE_W-1:0] MODE_70 = 7'h46;
	localparam logic [MODE_W-1:0] MODE_25 = 7'h19;
	localparam logic [MODE_W-1:0] MODE_52 = 7'h34;

	// ----------------------------------------------------------------
	// Layouts and lane counts per side
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LAY_NONE,
		LAY_DUAL12,
		LAY_D4_L4,
		LAY_D4_L8,
		LAY_D8_L2,
		LAY_D8_L4,
		LAY_D4_L16
	} slsp_layout_type;

	localparam logic [COUNT_W-1:0] ACT_NONE  = 4'h0;
	localparam logic [COUNT_W-1:0] ACT_DUAL  = 4'h6;
	localparam logic [COUNT_W-1:0] ACT_ONE   = 4'h1;
	localparam logic [COUNT_W-1:0] ACT_TWO   = 4'h2;
	localparam logic [COUNT_W-1:0] ACT_FOUR  = 4'h4;
	localparam logic [COUNT_W-1:0] ACT_EIGHT = 4'h8;

	localparam logic [LANE_W-1:0] LANE_RESET = 16'h0000;

endpackage

//--- verilog/slsp_iq_word.sv
/*
 * One decimated lane word: a 15-bit sample followed by its over-range
 * flag in the least significant bit, or zero on an idle lane.
 * Assumes the caller registers the result.
 */
module slsp_iq_word #(
	parameter int IQ_W   = slsp_pkg::IQ_W,
	parameter int LANE_W = slsp_pkg::LANE_W
) (
	input  wire logic [IQ_W-1:0]   sample,
	input  wire logic              flag,
	input  wire logic              enable,
	output logic      [LANE_W-1:0] word
);
	import slsp_pkg::*;

	// Sample fills the high octet first, flag closes the low octet
	assign word = enable ? {sample, flag} : LANE_RESET;

endmodule

//--- dv/slsp_rx_model.sv
/*
 * Receiver model for the bypass layouts: rebuilds the eight twelve-bit
 * samples of each channel from its six lane words.
 * Assumes lane 0 sits in the top bits of the frame it is given.
 */
module slsp_rx_model (
	input  wire logic [95:0] lanes_a,
	input  wire logic [95:0] lanes_b,
	output logic      [95:0] rx_a,
	output logic      [95:0] rx_b
);
	// ----------------------------------------------------------------
	// Reassembly
	// ----------------------------------------------------------------
	// octet then nibble order
	// Bits leave octet 0 first, nibble 0 first, so the frame is one
	// MSB-first stream of samples 0 to 7
	function automatic logic [95:0] unpack(input logic [95:0] frame);
		for (int k = 0; k < 8; k++) begin
			unpack[12*k +: 12] = frame[95-12*k -: 12];
		end
	endfunction

	assign rx_a = unpack(lanes_a);
	assign rx_b = unpack(lanes_b);
endmodule

//--- dv/testbench.sv
/*
 * Self-checking bench for the lane packer: a table of link modes, then
 * hold, refusal and reset cases.
 * Assumes the packer answers one cycle after each taken frame.
 */
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import slsp_pkg::*;

	typedef struct packed {
		logic [6:0] mode;
		logic [3:0] n;
		logic       shared;
		logic       bypass;
	} slsp_row_type;

	logic         sys_clk;
	logic         resetn;
	logic [6:0]   link_mode_select;
	logic         in_valid;
	logic [95:0]  chan_a;
	logic [95:0]  chan_b;
	logic [119:0] iq_i;
	logic [119:0] iq_q;
	logic [3:0]   overrange_i;
	logic [3:0]   overrange_q;
	logic         out_valid;
	logic         mode_supported;
	logic [15:0]  la [8];
	logic [15:0]  lb [8];
	logic [95:0]  rx_a;
	logic [95:0]  rx_b;
	int           num_errors = 0;
	int           comparisons = 0;
	int           cycles = 0;

	// Every supported mode with its lane count per side
	slsp_row_type rows [19] = '{
		'{MODE_20, 4'h6, 1'b0, 1'b1}, '{MODE_43, 4'h6, 1'b0, 1'b1},
		'{MODE_21, 4'h2, 1'b0, 1'b0}, '{MODE_36, 4'h2, 1'b0, 1'b0},
		'{MODE_22, 4'h4, 1'b0, 1'b0}, '{MODE_46, 4'h4, 1'b0, 1'b0},
		'{MODE_23, 4'h1, 1'b0, 1'b0}, '{MODE_38, 4'h1, 1'b0, 1'b0},
		'{MODE_61, 4'h1, 1'b0, 1'b0}, '{MODE_64, 4'h1, 1'b0, 1'b0},
		'{MODE_69, 4'h1, 1'b0, 1'b0}, '{MODE_71, 4'h1, 1'b0, 1'b0},
		'{MODE_24, 4'h2, 1'b0, 1'b0}, '{MODE_48, 4'h2, 1'b0, 1'b0},
		'{MODE_62, 4'h2, 1'b0, 1'b0}, '{MODE_65, 4'h2, 1'b0, 1'b0},
		'{MODE_70, 4'h2, 1'b0, 1'b0}, '{MODE_25, 4'h8, 1'b1, 1'b0},
		'{MODE_52, 4'h8, 1'b1, 1'b0}
	};

	slsp_packer slsp_packer_inst (
		.sys_clk(sys_clk), .resetn(resetn), .link_mode_select(link_mode_select),
		.in_valid(in_valid), .chan_a_samples(chan_a), .chan_b_samples(chan_b),
		.iq_i(iq_i), .iq_q(iq_q), .overrange_i(overrange_i), .overrange_q(overrange_q),
		.out_valid(out_valid), .mode_supported(mode_supported),
		.lane_a0(la[0]), .lane_a1(la[1]), .lane_a2(la[2]), .lane_a3(la[3]),
		.lane_a4(la[4]), .lane_a5(la[5]), .lane_a6(la[6]), .lane_a7(la[7]),
		.lane_b0(lb[0]), .lane_b1(lb[1]), .lane_b2(lb[2]), .lane_b3(lb[3]),
		.lane_b4(lb[4]), .lane_b5(lb[5]), .lane_b6(lb[6]), .lane_b7(lb[7])
	);

	slsp_rx_model slsp_rx_model_inst (
		.lanes_a({la[0], la[1], la[2], la[3], la[4], la[5]}),
		.lanes_b({lb[0], lb[1], lb[2], lb[3], lb[4], lb[5]}),
		.rx_a(rx_a),
		.rx_b(rx_b)
	);

	// ----------------------------------------------------------------
	// Clock and hang guard
	// ----------------------------------------------------------------
	always #2.5 sys_clk = ~sys_clk;

	// About 43 cycles are needed; the ceiling leaves ample slack
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// Checking tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [119:0] seen, input logic [119:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	// Expected words come from the current inputs; sup low expects zeros
	task automatic check_lanes(input slsp_row_type r, input logic sup, input logic vld);
		logic [95:0] fa;
		logic [95:0] fb;
		logic [15:0] ea;
		logic [15:0] eb;
		int          f;
		for (int k = 0; k < 8; k++) begin
			fa[95-12*k -: 12] = chan_a[12*k +: 12];
			fb[95-12*k -: 12] = chan_b[12*k +: 12];
		end
		for (int l = 0; l < 8; l++) begin
			f = r.shared ? l / 2 : l;
			ea = 16'h0000;
			eb = 16'h0000;
			if (sup && r.bypass && l < 6) begin
				ea = fa[95-16*l -: 16];
				eb = fb[95-16*l -: 16];
			end else if (sup && !r.bypass && l < r.n) begin
				ea = {iq_i[15*l +: 15], overrange_i[f]};
				eb = {iq_q[15*l +: 15], overrange_q[f]};
			end
			check("lane_a", la[l], ea);
			check("lane_b", lb[l], eb);
		end
		check("out_valid", out_valid, vld);
		check("mode_supported", mode_supported, sup);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		resetn = 1'b0;
		link_mode_select = MODE_20;
		in_valid = 1'b0;
		chan_a = 96'h123456789ABCDEF0FEDCBA98;
		chan_b = 96'h0F1E2D3C4B5A69788796A5B4;
		iq_i = 120'h0123456789ABCDEFFEDCBA98765432;
		iq_q = 120'h13579BDF02468ACE13579BDF02468A;
		overrange_i = 4'hA;
		overrange_q = 4'h6;
		repeat (12) @(posedge sys_clk);
		#1;
		check_lanes(rows[0], 1'b0, 1'b0);
		resetn = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		$display("test reset done");
		// Back-to-back frames, data shifted every frame
		foreach (rows[i]) begin
			link_mode_select = rows[i].mode;
			in_valid = 1'b1;
			@(posedge sys_clk);
			#1;
			check_lanes(rows[i], 1'b1, 1'b1);
			if (rows[i].bypass) begin
				check("rx_a", rx_a, chan_a);
				check("rx_b", rx_b, chan_b);
			end
			chan_a = {chan_a[94:0], chan_a[95]};
			chan_b = {chan_b[94:0], chan_b[95]};
			iq_i = {iq_i[118:0], iq_i[119]};
			iq_q = {iq_q[118:0], iq_q[119]};
			overrange_i = {overrange_i[2:0], overrange_i[3]};
			overrange_q = {overrange_q[2:0], overrange_q[3]};
			$display("test mode %0d done", rows[i].mode);
		end
		// Idle cycle: lanes keep the last frame although inputs move
		link_mode_select = MODE_20;
		in_valid = 1'b1;
		@(posedge sys_clk);
		#1;
		in_valid = 1'b0;
		chan_a = ~chan_a;
		chan_b = ~chan_b;
		@(posedge sys_clk);
		#1;
		chan_a = ~chan_a;
		chan_b = ~chan_b;
		check_lanes(rows[0], 1'b1, 1'b0);
		$display("test hold done");
		// Unsupported modes still count as frames but carry nothing
		link_mode_select = 7'h1A;
		in_valid = 1'b1;
		@(posedge sys_clk);
		#1;
		check_lanes(rows[0], 1'b0, 1'b1);
		link_mode_select = 7'h7F;
		@(posedge sys_clk);
		#1;
		check_lanes(rows[0], 1'b0, 1'b1);
		$display("test refusal done");
		// Reset in mid-run clears at once, then a frame recovers
		link_mode_select = MODE_43;
		resetn = 1'b0;
		#1;
		check_lanes(rows[1], 1'b0, 1'b0);
		@(posedge sys_clk);
		#1;
		resetn = 1'b1;
		in_valid = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		in_valid = 1'b1;
		@(posedge sys_clk);
		#1;
		check_lanes(rows[1], 1'b1, 1'b1);
		in_valid = 1'b0;
		$display("test second reset done");
		results();
	end
endmodule
